/* File: design/brs_pkg.sv */
// Constants and carrier types for the bus ready synchronizer.
// Assumes a single 100 MHz system clock; the processor clock is derived from it.
package brs_pkg;

	// System clock period and the derived processor clock period
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int CPU_CLK_PERIOD_NS = 30;
	localparam int CPU_DIV = CPU_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
	localparam logic [1:0] CPU_DIV_LAST = 2'(CPU_DIV - 1);

	// Phase counter values that mark the processor clock edges
	localparam logic [1:0] PHASE_RISE = 2'h0;
	localparam logic [1:0] PHASE_FALL = 2'h1;

	// Reset values
	localparam logic [1:0] CNT_RESET = 2'h0;
	localparam logic STAGE_RESET = 1'h0;

	// One bus ready input with its active-low address qualifier
	typedef struct packed {
		logic ready;
		logic address_enable_qual_n;
	} brs_rdy_req_s;

endpackage

/* File: design/brs_clk_div.sv */
// Processor clock phase divider: one-cycle rise and fall enables.
// Assumes the system clock is the only clock; the processor clock is 1/3 duty.
`timescale 1ns/10ps
`default_nettype none
module brs_clk_div (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Processor clock phase enables and the processor clock
	output logic rise_en_o,
	output logic fall_en_o,
	output logic cpu_clk_o
);

	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic cpu_clk_ff;
	logic nxt_cpu_clk;

	always_comb
	begin
		nxt_cnt = (cnt_ff == brs_pkg::CPU_DIV_LAST) ? brs_pkg::CNT_RESET : cnt_ff + 2'h1;
		nxt_cpu_clk = (nxt_cnt == brs_pkg::PHASE_RISE);
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_ff <= brs_pkg::CNT_RESET;
			cpu_clk_ff <= 1'h0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			cpu_clk_ff <= nxt_cpu_clk;
		end
	end

	// Edges are enables in the system domain, never real clock edges
	assign rise_en_o = (cnt_ff == brs_pkg::PHASE_RISE);
	assign fall_en_o = (cnt_ff == brs_pkg::PHASE_FALL);
	assign cpu_clk_o = cpu_clk_ff;

endmodule
`default_nettype wire

/* File: design/brs_ready_sync.sv */
// Bus ready synchronizer: two qualified ready inputs to one processor ready.
// Assumes inputs are synchronous to clock_i; processor clock edges are enables.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Two bus ready inputs, each with qualifier
// - Ready counts only while its qualifier low
// - Rising ready always passes through synchronizer
// - Select low: rise via stage one, two
// - Select low: fall straight into stage two
// - Select high: stage two only, falling edge
// - Select may change every bus cycle
// - Select has no pull-up: tie high for one stage
// - Ready clears once hold time is met
module brs_ready_sync (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Bus ready inputs with qualifiers
	input wire brs_pkg::brs_rdy_req_s bus_first_i,
	input wire brs_pkg::brs_rdy_req_s bus_second_i,
	// Mode select, tie high when unused
	input wire logic sync_stage_select_i,
	// Processor side
	output logic ready_o,
	output logic cpu_clk_o
);

	logic rise_en;
	logic fall_en;
	logic qual_ready;
	logic qual_first;
	logic qual_second;
	logic stage_one_ff;
	logic nxt_stage_one;
	logic stage_two_ff;
	logic nxt_stage_two;

	brs_clk_div u_clk_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.rise_en_o(rise_en),
		.fall_en_o(fall_en),
		.cpu_clk_o(cpu_clk_o)
	);

	// Each ready is gated by its own active-low qualifier
	assign qual_first = bus_first_i.ready & ~bus_first_i.address_enable_qual_n;
	assign qual_second = bus_second_i.ready & ~bus_second_i.address_enable_qual_n;
	// Either bus may answer; a bus that is not addressed cannot
	assign qual_ready = qual_first | qual_second;

	always_comb
	begin
		nxt_stage_one = stage_one_ff;
		nxt_stage_two = stage_two_ff;
		if (rise_en)
		begin
			nxt_stage_one = qual_ready;
		end
		if (fall_en)
		begin
			// Mode is taken per falling edge so each bus cycle may differ
			if (sync_stage_select_i)
			begin
				nxt_stage_two = qual_ready;
			end
			else
			begin
				// A high needs stage one; a low bypasses it
				nxt_stage_two = qual_ready & stage_one_ff;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			stage_one_ff <= brs_pkg::STAGE_RESET;
			stage_two_ff <= brs_pkg::STAGE_RESET;
		end
		else
		begin
			stage_one_ff <= nxt_stage_one;
			stage_two_ff <= nxt_stage_two;
		end
	end

	assign ready_o = stage_two_ff;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_arm_two;
		rise_en && qual_ready && !sync_stage_select_i;
	endsequence

	sequence s_take_two;
		fall_en && qual_ready && !sync_stage_select_i;
	endsequence

	property p_two_stage;
		s_arm_two ##1 s_take_two |=> ready_o;
	endproperty

	a_two_stage_rise: assert property (p_two_stage)
		else $error("ready did not rise after two stages");

	a_stage_one_sample: assert property (rise_en |=> stage_one_ff == $past(qual_ready))
		else $error("stage one missed its sample");

	a_no_shortcut: assert property (
		fall_en && !sync_stage_select_i && !stage_one_ff |=> !ready_o)
		else $error("ready rose without stage one");

	a_direct_fall: assert property (
		fall_en && !sync_stage_select_i && !qual_ready |=> !ready_o)
		else $error("ready did not fall directly");

	a_single_stage: assert property (
		fall_en && sync_stage_select_i |=> ready_o == $past(qual_ready))
		else $error("single stage capture wrong");

	a_mode_switch: assert property (
		fall_en && sync_stage_select_i && !$past(sync_stage_select_i)
		|=> ready_o == $past(qual_ready))
		else $error("new mode not honoured");

	a_qualifier_gate: assert property (
		fall_en && bus_first_i.address_enable_qual_n && bus_second_i.address_enable_qual_n
		|=> !ready_o)
		else $error("unqualified ready passed");

	sequence s_ready_left;
		ready_o && !qual_ready;
	endsequence

	// The input must stay low up to the falling edge, else ready may rise again
	sequence s_low_to_fall;
		(!qual_ready && !fall_en) ##1 (!qual_ready && fall_en);
	endsequence

	a_ready_clear: assert property (
		s_ready_left ##1 s_low_to_fall |=> !ready_o)
		else $error("ready not cleared");

	a_hold_between: assert property (!fall_en |=> $stable(ready_o))
		else $error("ready moved off a falling edge");

	a_reset_low: assert property (@(posedge clock_i) disable iff (1'b0)
		!rstn_i |-> !ready_o && !stage_one_ff)
		else $error("stages not cleared in reset");

	// Processor clock phases: rise enable, fall enable, then one idle cycle
	sequence s_rise_phase;
		rise_en && !fall_en;
	endsequence

	sequence s_fall_phase;
		fall_en && !rise_en;
	endsequence

	sequence s_idle_phase;
		!rise_en && !fall_en;
	endsequence

	property p_phase_cycle;
		s_rise_phase |=> s_fall_phase ##1 s_idle_phase ##1 s_rise_phase;
	endproperty

	a_phase_cycle: assert property (p_phase_cycle)
		else $error("processor clock phases out of order");

	a_clock_high: assert property (fall_en |-> ##2 cpu_clk_o)
		else $error("processor clock not high in its rise phase");

	a_clock_low: assert property (!rise_en |-> !cpu_clk_o)
		else $error("processor clock high outside its rise phase");

	a_stage_one_hold: assert property (!rise_en |=> $stable(stage_one_ff))
		else $error("stage one moved off a rising edge");

	// A two-stage rise needs the input already high at the rise enable
	property p_armed_rise;
		fall_en && !sync_stage_select_i |=> !ready_o || $past(qual_ready, 2);
	endproperty

	a_armed_rise: assert property (p_armed_rise)
		else $error("two-stage ready rose without being armed");

	a_rise_source: assert property (
		$rose(ready_o) |-> $past(fall_en) && $past(qual_ready))
		else $error("ready rose without a qualified input");

	a_fall_source: assert property (
		$fell(ready_o) |-> $past(fall_en) && !$past(qual_ready))
		else $error("ready fell off a falling edge");

	// Once moved, ready stands until the next falling edge enable
	property p_ready_stands;
		$changed(ready_o) |-> ##1 $stable(ready_o) ##1 $stable(ready_o);
	endproperty

	a_ready_stands: assert property (p_ready_stands)
		else $error("ready did not stand for a processor period");

	a_single_fall: assert property (
		fall_en && sync_stage_select_i && !qual_ready |=> !ready_o)
		else $error("single stage ready did not clear");

	a_first_alone: assert property (
		fall_en && sync_stage_select_i && !bus_first_i.address_enable_qual_n
		&& bus_second_i.address_enable_qual_n |=> ready_o == $past(bus_first_i.ready))
		else $error("first bus ready not followed on its own");

	a_second_alone: assert property (
		fall_en && sync_stage_select_i && bus_first_i.address_enable_qual_n
		&& !bus_second_i.address_enable_qual_n |=> ready_o == $past(bus_second_i.ready))
		else $error("second bus ready not followed on its own");

endmodule
`default_nettype wire

/* File: testbench/brs_bus_dev.sv */
// Bus device model: one ready line and its address qualifier.
// Assumes the bench moves its controls just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module brs_bus_dev (
	// Bench controls
	input wire logic rdy_i,
	input wire logic sel_i,
	// Bus side
	output var brs_pkg::brs_rdy_req_s bus_o
);
	// Drops are unsynchronised but land after an edge, so setup and hold hold
	assign bus_o.ready = rdy_i;
	assign bus_o.address_enable_qual_n = ~sel_i;
endmodule
`default_nettype wire

/* File: testbench/brs_ready_sync_bench.sv */
// Self-checking bench for the bus ready synchronizer.
// Assumes one 100 MHz clock; phase is found from cpu_clk_o.
`timescale 1ns/10ps
`default_nettype none
module brs_ready_sync_bench;
	logic clock_i = 1'h0;
	logic rstn_i = 1'h0;
	logic sel = 1'h1;
	logic r1 = 1'h0, e1 = 1'h1, r2 = 1'h0, e2 = 1'h0;
	logic ready_o, cpu_clk_o;
	brs_pkg::brs_rdy_req_s b1, b2;
	int n_mismatch = 0;
	int compares = 0;
	brs_bus_dev u_dev1 (.rdy_i(r1), .sel_i(e1), .bus_o(b1));
	brs_bus_dev u_dev2 (.rdy_i(r2), .sel_i(e2), .bus_o(b2));
	brs_ready_sync u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .bus_first_i(b1),
		.bus_second_i(b2), .sync_stage_select_i(sel), .ready_o(ready_o),
		.cpu_clk_o(cpu_clk_o));
	always #5 clock_i = ~clock_i;
	task ed(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task chk(input logic e);
		compares++;
		if (ready_o !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t ready_o %b", $time, ready_o);
		end
	endtask
	// Lands after the stage-one edge, so a rise now misses stage one
	task to_fall;
		ed(1);
		while (cpu_clk_o !== 1'h1) ed(1);
		ed(1);
	endtask
	task t_single;
		// Switched just before the falling edge, as a new bus cycle may ask
		to_fall;
		sel = 1'h1;
		r1 = 1'h1;
		ed(1);
		chk(1'h1);
		r1 = 1'h0;
		ed(1);
		chk(1'h1);
		ed(2);
		chk(1'h0);
		$display("single stage done");
	endtask
	task t_double;
		to_fall;
		sel = 1'h0;
		r1 = 1'h1;
		ed(1);
		chk(1'h0);
		ed(3);
		chk(1'h1);
		ed(2);
		r1 = 1'h0;
		ed(1);
		chk(1'h0);
		$display("two stage done");
	endtask
	task t_qual;
		to_fall;
		r1 = 1'h1;
		e1 = 1'h0;
		r2 = 1'h1;
		ed(3);
		chk(1'h0);
		e2 = 1'h1;
		ed(1);
		chk(1'h1);
		r2 = 1'h0;
		e2 = 1'h0;
		ed(3);
		chk(1'h0);
		r1 = 1'h0;
		e1 = 1'h1;
		$display("qualifier done");
	endtask
	task t_reset;
		to_fall;
		r1 = 1'h1;
		ed(1);
		chk(1'h1);
		rstn_i = 1'h0;
		ed(1);
		chk(1'h0);
		ed(2);
		rstn_i = 1'h1;
		ed(1);
		chk(1'h0);
		ed(1);
		chk(1'h1);
		r1 = 1'h0;
		ed(3);
		chk(1'h0);
		$display("mid-run reset done");
	endtask
	task t_clock;
		int n_high;
		n_high = 0;
		to_fall;
		repeat (2 * brs_pkg::CPU_DIV)
		begin
			ed(1);
			if (cpu_clk_o === 1'h1)
				n_high++;
		end
		compares++;
		if (n_high != 2)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t processor clock high %0d times", $time, n_high);
		end
		$display("processor clock done");
	endtask
	task close_out;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		ed(20);
		chk(1'h0);
		rstn_i = 1'h1;
		t_single;
		t_double;
		t_single;
		t_qual;
		t_reset;
		t_clock;
		close_out;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
